// ===== hdl/eeprom_pkg.sv
// shared constants for the eeprom byte access controller and its cpu end
package eeprom_pkg;

    // ==========================================================
    // array geometry
    localparam int EE_DEPTH      = 512;
    localparam int EE_ADDR_WIDTH = 9;
    localparam int EE_DATA_WIDTH = 8;
    localparam int ADDR_LOW_BITS = 8;  // address bits held in the low register

    // ==========================================================
    // io register indexes seen by the cpu
    localparam logic [1:0] REG_ADDR_LOW  = 2'h0;
    localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
    localparam logic [1:0] REG_DATA      = 2'h2;
    localparam logic [1:0] REG_CONTROL   = 2'h3;

    // ==========================================================
    // control register bit positions
    localparam int CTL_READ_STROBE  = 0;
    localparam int CTL_WRITE_STROBE = 1;
    localparam int CTL_MASTER_WE    = 2;
    localparam int CTL_READY_IE     = 3;

    // ==========================================================
    // timing
    localparam int CLK_HZ             = 40_000_000;
    localparam int OSC_HZ             = 1_000_000;
    localparam int WRITE_OSC_CYCLES   = 8448;
    localparam int WRITE_CYCLES_DFLT  = WRITE_OSC_CYCLES * (CLK_HZ / OSC_HZ);
    localparam int MWE_WINDOW_CYCLES  = 4;
    localparam int READ_STALL_CYCLES  = 4;
    localparam int WRITE_STALL_CYCLES = 2;

    // ==========================================================
    // avalon register byte offsets of the cpu end
    localparam logic [3:0] AV_ADDR   = 4'h0;
    localparam logic [3:0] AV_DATA   = 4'h4;
    localparam logic [3:0] AV_CMD    = 4'h8;
    localparam logic [3:0] AV_STATUS = 4'hC;

    // command register bits
    localparam int CMD_READ      = 0;
    localparam int CMD_WRITE     = 1;
    localparam int CMD_READY_IE  = 2;
    localparam int CMD_GLOBAL_IE = 3;

    // status register bits
    localparam int ST_BUSY       = 0;
    localparam int ST_IRQ        = 1;
    localparam int ST_WRITING    = 2;
    localparam int ST_FLASH_BUSY = 3;

endpackage : eeprom_pkg

// ===== hdl/eeprom_io_if.sv
// io register link between the cpu end and the eeprom controller
`timescale 1ns/100ps

interface eeprom_io_if;
    logic [1:0] addr;       // register index
    logic [7:0] wdata;      // write data
    logic       we;         // one-cycle write
    logic       re;         // one-cycle read
    logic [7:0] rdata;      // read data, valid the cycle after re
    logic       stall;      // cpu halted
    logic       irq;        // eeprom ready interrupt level
    logic       global_ie;  // global interrupt enable of the cpu
    logic       flash_busy; // self program enable flag

    modport device (input addr, wdata, we, re, global_ie, flash_busy,
                    output rdata, stall, irq);
    modport cpu    (output addr, wdata, we, re, global_ie, flash_busy,
                    input rdata, stall, irq);
endinterface : eeprom_io_if

// ===== hdl/eeprom_byte_access_ctrl.sv
// eeprom byte access controller: io registers, self-timed write engine, array
`timescale 1ns/100ps

module eeprom_byte_access_ctrl #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DFLT,
    parameter int DEPTH        = eeprom_pkg::EE_DEPTH
) (
    input  wire logic   clk_sys,
    input  wire logic   resetn,
    input  wire logic   por_n,
    eeprom_io_if.device io
);

    // ==========================================================
    // local widths and load values
    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam int AW = eeprom_pkg::EE_ADDR_WIDTH;
    localparam int DW = eeprom_pkg::EE_DATA_WIDTH;
    localparam int LB = eeprom_pkg::ADDR_LOW_BITS;
    localparam logic [TW-1:0] WR_LOAD  = TW'(WRITE_CYCLES - 1);
    localparam logic [2:0]    MWE_LOAD = 3'(eeprom_pkg::MWE_WINDOW_CYCLES - 1);
    localparam logic [2:0]    RD_STALL = 3'(eeprom_pkg::READ_STALL_CYCLES - 1);
    localparam logic [2:0]    WR_STALL = 3'(eeprom_pkg::WRITE_STALL_CYCLES - 1);

    // ==========================================================
    // decode helper
    function automatic logic wr_hit(input logic we, input logic [1:0] a,
                                    input logic [1:0] r);
        wr_hit = we && (a == r);
    endfunction : wr_hit

    // ==========================================================
    // state
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] ee_addr;
    logic [DW-1:0] eeprom_data_byte;
    logic          ready_interrupt_enable;
    logic          master_write_enable;
    logic [2:0]    mwe_cnt;
    logic          write_busy;
    logic [TW-1:0] wr_timer;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [2:0]    stall_cnt;
    logic [DW-1:0] next_control;
    logic          ctl_wr;
    logic          read_go;
    logic          write_go;
    logic          write_done;

    // control write triggers
    assign ctl_wr     = wr_hit(io.we, io.addr, eeprom_pkg::REG_CONTROL);
    assign read_go    = ctl_wr && io.wdata[eeprom_pkg::CTL_READ_STROBE]
                        && !write_busy;
    assign write_go   = ctl_wr && io.wdata[eeprom_pkg::CTL_WRITE_STROBE]
                        && master_write_enable
                        && !write_busy
                        && !io.flash_busy;
    assign write_done = write_busy && (wr_timer == '0);

    // ==========================================================
    // address pair, deliberately left without reset
    always_ff @(posedge clk_sys)
    begin
        if (!write_busy)
        begin
            if (wr_hit(io.we, io.addr, eeprom_pkg::REG_ADDR_LOW))
            begin
                ee_addr[LB-1:0] <= io.wdata[LB-1:0];
            end
            if (wr_hit(io.we, io.addr, eeprom_pkg::REG_ADDR_HIGH))
            begin
                ee_addr[AW-1:LB] <= io.wdata[AW-LB-1:0];
            end
        end
    end

    // ==========================================================
    // data register: software write or fetch from the array
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            eeprom_data_byte <= '0;
        end
        else if (wr_hit(io.we, io.addr, eeprom_pkg::REG_DATA))
        begin
            eeprom_data_byte <= io.wdata;
        end
        else if (read_go)
        begin
            eeprom_data_byte <= mem[ee_addr];
        end
    end

    // ==========================================================
    // ready enable and master write enable with its timeout
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ready_interrupt_enable <= 1'b0;
            master_write_enable    <= 1'b0;
            mwe_cnt                <= '0;
        end
        else if (ctl_wr)
        begin
            ready_interrupt_enable <= io.wdata[eeprom_pkg::CTL_READY_IE];
            master_write_enable    <= io.wdata[eeprom_pkg::CTL_MASTER_WE];
            mwe_cnt                <= MWE_LOAD;
        end
        else if (master_write_enable)
        begin
            if (mwe_cnt == '0)
            begin
                master_write_enable <= 1'b0;
            end
            else
            begin
                mwe_cnt <= mwe_cnt - 3'h1;
            end
        end
    end

    // ==========================================================
    // write engine on power-on reset only, so a system reset lets it finish
    always_ff @(posedge clk_sys or negedge por_n)
    begin
        if (!por_n)
        begin
            write_busy <= 1'b0;
            wr_timer   <= '0;
            wr_addr    <= '0;
            wr_data    <= '0;
        end
        else if (write_go)
        begin
            write_busy <= 1'b1;
            wr_timer   <= WR_LOAD;
            wr_addr    <= ee_addr;
            wr_data    <= eeprom_data_byte;
        end
        else if (write_busy)
        begin
            // timer has no sleep gate, it runs through power-down
            if (write_done)
            begin
                write_busy <= 1'b0;
            end
            else
            begin
                wr_timer <= wr_timer - TW'(1);
            end
        end
    end

    // ==========================================================
    // array update at the end of the write time
    always_ff @(posedge clk_sys)
    begin
        if (write_done)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ==========================================================
    // cpu stall after read trigger or write start
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stall_cnt <= '0;
            io.stall  <= 1'b0;
        end
        else if (read_go)
        begin
            stall_cnt <= RD_STALL;
            io.stall  <= 1'b1;
        end
        else if (write_go)
        begin
            stall_cnt <= WR_STALL;
            io.stall  <= 1'b1;
        end
        else if (stall_cnt != '0)
        begin
            stall_cnt <= stall_cnt - 3'h1;
        end
        else
        begin
            io.stall <= 1'b0;
        end
    end

    // ==========================================================
    // ready interrupt level
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            io.irq <= 1'b0;
        end
        else
        begin
            io.irq <= ready_interrupt_enable && io.global_ie && !write_busy;
        end
    end

    // ==========================================================
    // control readback, strobe for reads always zero
    always_comb
    begin
        next_control = '0;
        next_control[eeprom_pkg::CTL_READY_IE]     = ready_interrupt_enable;
        next_control[eeprom_pkg::CTL_MASTER_WE]    = master_write_enable;
        next_control[eeprom_pkg::CTL_WRITE_STROBE] = write_busy;
    end

    // ==========================================================
    // register read port, data one cycle after re
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            io.rdata <= '0;
        end
        else if (io.re)
        begin
            if (io.addr == eeprom_pkg::REG_ADDR_LOW)
            begin
                io.rdata <= ee_addr[LB-1:0];
            end
            else if (io.addr == eeprom_pkg::REG_ADDR_HIGH)
            begin
                io.rdata <= DW'(ee_addr[AW-1:LB]);
            end
            else if (io.addr == eeprom_pkg::REG_DATA)
            begin
                io.rdata <= eeprom_data_byte;
            end
            else
            begin
                io.rdata <= next_control;
            end
        end
    end

endmodule : eeprom_byte_access_ctrl

// ===== hdl/eeprom_cpu_end.sv
// cpu end: runs eeprom read and write sequences on avalon commands
`timescale 1ns/100ps

module eeprom_cpu_end (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        flash_prog_busy,
    eeprom_io_if.cpu         io
);

    // ==========================================================
    // sequencer states
    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_POLL  = 9'h002,
        S_AHIGH = 9'h004,
        S_ALOW  = 9'h008,
        S_DATA  = 9'h010,
        S_MWE   = 9'h020,
        S_STROB = 9'h040,
        S_RDATA = 9'h080,
        S_DONE  = 9'h100
    } seq_state_t;

    seq_state_t state;
    logic [8:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [7:0] read_byte;
    logic       op_write;
    logic       ready_ie;
    logic       global_ie;
    logic       dev_writing;
    logic       settle;
    logic       sample;
    logic       av_wr;
    logic       cmd_go;
    logic [7:0] ctl_base;

    // ==========================================================
    // avalon handshake: one wait cycle, then the answer
    assign av_wr  = avs_write && !avs_waitrequest;
    assign cmd_go = av_wr && (avs_address == eeprom_pkg::AV_CMD) && (state == S_IDLE)
                    && (avs_writedata[eeprom_pkg::CMD_READ]
                        || avs_writedata[eeprom_pkg::CMD_WRITE]);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            if (avs_address == eeprom_pkg::AV_ADDR)
            begin
                avs_readdata <= 32'(cmd_addr);
            end
            else if (avs_address == eeprom_pkg::AV_DATA)
            begin
                avs_readdata <= 32'(read_byte);
            end
            else if (avs_address == eeprom_pkg::AV_CMD)
            begin
                avs_readdata <= (32'(ready_ie) << eeprom_pkg::CMD_READY_IE)
                              | (32'(global_ie) << eeprom_pkg::CMD_GLOBAL_IE);
            end
            else if (avs_address == eeprom_pkg::AV_STATUS)
            begin
                avs_readdata <= (32'(state != S_IDLE) << eeprom_pkg::ST_BUSY)
                              | (32'(io.irq) << eeprom_pkg::ST_IRQ)
                              | (32'(dev_writing) << eeprom_pkg::ST_WRITING)
                              | (32'(io.flash_busy) << eeprom_pkg::ST_FLASH_BUSY);
            end
            else
            begin
                avs_readdata <= '0;
            end
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ==========================================================
    // software registers, address and data frozen while busy
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_addr  <= '0;
            cmd_data  <= '0;
            ready_ie  <= 1'b0;
            global_ie <= 1'b0;
        end
        else if (av_wr)
        begin
            if (avs_address == eeprom_pkg::AV_ADDR && state == S_IDLE)
            begin
                cmd_addr <= avs_writedata[8:0];
            end
            else if (avs_address == eeprom_pkg::AV_DATA && state == S_IDLE)
            begin
                cmd_data <= avs_writedata[7:0];
            end
            else if (avs_address == eeprom_pkg::AV_CMD)
            begin
                ready_ie  <= avs_writedata[eeprom_pkg::CMD_READY_IE];
                global_ie <= avs_writedata[eeprom_pkg::CMD_GLOBAL_IE];
            end
        end
    end

    // control byte common to both control writes
    always_comb
    begin
        ctl_base = '0;
        ctl_base[eeprom_pkg::CTL_READY_IE]  = ready_ie;
        ctl_base[eeprom_pkg::CTL_MASTER_WE] = op_write;
    end

    // ==========================================================
    // io sequencer: issue one access, settle one cycle (two for a read), then advance
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= S_IDLE;
            op_write    <= 1'b0;
            settle      <= 1'b0;
            sample      <= 1'b0;
            dev_writing <= 1'b0;
            read_byte   <= '0;
            io.addr     <= '0;
            io.wdata    <= '0;
            io.we       <= 1'b0;
            io.re       <= 1'b0;
        end
        else
        begin
            io.we  <= 1'b0;
            io.re  <= 1'b0;
            settle <= 1'b0;
            sample <= 1'b0;
            if (cmd_go)
            begin
                op_write <= avs_writedata[eeprom_pkg::CMD_WRITE];
                state    <= S_POLL;
            end
            else if (settle)
            begin
                case (state)
                    S_POLL:  sample <= 1'b1; // read data lands a cycle after re
                    S_AHIGH: state <= S_ALOW;
                    S_ALOW:  state <= op_write ? S_DATA : S_STROB;
                    S_DATA:  state <= S_MWE;
                    S_MWE:   state <= S_STROB;
                    S_STROB: state <= op_write ? S_DONE : S_RDATA;
                    S_RDATA: sample <= 1'b1;
                    default: state <= S_IDLE;
                endcase
            end
            // second settle cycle of a read: rdata now holds the answer
            else if (sample)
            begin
                if (state == S_POLL)
                begin
                    dev_writing <= io.rdata[eeprom_pkg::CTL_WRITE_STROBE];
                    if (!io.rdata[eeprom_pkg::CTL_WRITE_STROBE]
                        && !(op_write && io.flash_busy))
                    begin
                        state <= S_AHIGH;
                    end
                end
                else
                begin
                    read_byte <= io.rdata;
                    state     <= S_DONE;
                end
            end
            else if (state == S_DONE)
            begin
                state <= S_IDLE;
            end
            else if (state != S_IDLE && !io.stall)
            begin
                settle <= 1'b1;
                case (state)
                    S_POLL:
                    begin
                        io.addr <= eeprom_pkg::REG_CONTROL;
                        io.re   <= 1'b1;
                    end
                    S_AHIGH:
                    begin
                        io.addr  <= eeprom_pkg::REG_ADDR_HIGH;
                        io.wdata <= 8'(cmd_addr[8]);
                        io.we    <= 1'b1;
                    end
                    S_ALOW:
                    begin
                        io.addr  <= eeprom_pkg::REG_ADDR_LOW;
                        io.wdata <= cmd_addr[7:0];
                        io.we    <= 1'b1;
                    end
                    S_DATA:
                    begin
                        io.addr  <= eeprom_pkg::REG_DATA;
                        io.wdata <= cmd_data;
                        io.we    <= 1'b1;
                    end
                    S_MWE:
                    begin
                        io.addr  <= eeprom_pkg::REG_CONTROL;
                        io.wdata <= ctl_base;
                        io.we    <= 1'b1;
                    end
                    S_STROB:
                    begin
                        io.addr  <= eeprom_pkg::REG_CONTROL;
                        io.wdata <= ctl_base
                                    | (8'(op_write) << eeprom_pkg::CTL_WRITE_STROBE)
                                    | (8'(!op_write) << eeprom_pkg::CTL_READ_STROBE);
                        io.we    <= 1'b1;
                    end
                    default:
                    begin
                        io.addr <= eeprom_pkg::REG_DATA;
                        io.re   <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // flash flag registered as is, global enable masked through a write sequence
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            io.flash_busy <= 1'b0;
            io.global_ie  <= 1'b0;
        end
        else
        begin
            io.flash_busy <= flash_prog_busy;
            io.global_ie  <= global_ie && !(op_write && state != S_IDLE);
        end
    end

endmodule : eeprom_cpu_end

// ===== verif/eeprom_io_properties.sv
// concurrent checks on the io link between the cpu end and the controller
`timescale 1ns/100ps

module eeprom_io_properties (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       we,
    input wire logic       re,
    input wire logic [7:0] rdata,
    input wire logic       stall,
    input wire logic       irq,
    input wire logic       global_ie,
    input wire logic       flash_busy
);
    // ==========================================================
    // helper state: enable window mirror, stall length
    logic       ctl_wr;
    logic       rd_go;
    logic       wr_go;
    logic [2:0] mwe_cnt;
    logic [2:0] stall_cnt;

    // control write decode
    assign ctl_wr = we && addr == eeprom_pkg::REG_CONTROL;
    assign rd_go  = ctl_wr && wdata[0];
    assign wr_go  = ctl_wr && wdata[1] && !wdata[0] && mwe_cnt != 3'h0 && !flash_busy;

    // master write enable window, four cycles after each set
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            mwe_cnt <= 3'h0;
        else if (ctl_wr)
            mwe_cnt <= wdata[eeprom_pkg::CTL_MASTER_WE] ? 3'h4 : 3'h0;
        else if (mwe_cnt != 3'h0)
            mwe_cnt <= mwe_cnt - 3'h1;

    // consecutive stall cycles
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            stall_cnt <= 3'h0;
        else
            stall_cnt <= stall ? stall_cnt + 3'h1 : 3'h0;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // assertions
    AST_READ_STALL: assert property (rd_go |=> stall[*4] ##1 !stall)
        else $error("read stall not four cycles");
    AST_WRITE_STALL: assert property (wr_go |=> stall[*2] ##1 !stall)
        else $error("write stall not two cycles");
    AST_STALL_MAX: assert property (stall_cnt <= 3'h4)
        else $error("stall too long");
    AST_STALL_CAUSE: assert property ($rose(stall) |-> $past(rd_go || wr_go))
        else $error("stall without a started access");
    AST_MWE_CLEAR: assert property (re && addr == eeprom_pkg::REG_CONTROL |=>
        rdata[eeprom_pkg::CTL_MASTER_WE] == $past(mwe_cnt != 3'h0))
        else $error("master write enable window wrong");
    AST_CTL_RESERVED: assert property (re && addr == eeprom_pkg::REG_CONTROL |=>
        rdata[7:4] == 4'h0 && !rdata[0])
        else $error("control reserved bits not zero");
    AST_IRQ_GATE: assert property (!global_ie |=> !irq)
        else $error("irq without global enable");
    AST_IRQ_WRITING: assert property (wr_go |-> ##2 !irq[*3])
        else $error("irq during write");
    AST_RDATA_HOLD: assert property (!re |=> $stable(rdata))
        else $error("read data changed without read");

    C_READ: cover property (rd_go);
    C_WRITE: cover property (wr_go);
    C_IRQ: cover property ($rose(irq));
endmodule : eeprom_io_properties

// ===== verif/eeprom_byte_access_ctrl_tb_top.sv
// self-checking bench for the eeprom controller and its cpu end
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module eeprom_byte_access_ctrl_tb_top;
    logic        clk_sys         = 1'b0;
    logic        resetn          = 1'b0;
    logic        por_n           = 1'b0;
    logic [3:0]  avs_address     = 4'h0;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic        flash_prog_busy = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] q;
    int          n;
    int          failures        = 0;
    int          checks          = 0;
    // rows: address and byte; ie rows: irq expected, command bits
    logic [16:0] rows [4]    = '{17'h000A5, 17'h1FF3C, 17'h1005A, 17'h0FFC3};
    logic [4:0]  ie_rows [5] = '{5'h1C, 5'h04, 5'h1C, 5'h08, 5'h00};

    always #12.5 clk_sys = ~clk_sys;

    eeprom_io_if io ();
    eeprom_byte_access_ctrl #(.WRITE_CYCLES(20)) eeprom_byte_access_ctrl_i (
        .clk_sys(clk_sys), .resetn(resetn), .por_n(por_n), .io(io));
    eeprom_cpu_end eeprom_cpu_end_i (
        .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .flash_prog_busy(flash_prog_busy), .io(io));
    eeprom_io_properties eeprom_io_properties_i (
        .clk_sys(clk_sys), .resetn(resetn), .addr(io.addr), .wdata(io.wdata),
        .we(io.we), .re(io.re), .rdata(io.rdata), .stall(io.stall), .irq(io.irq),
        .global_ie(io.global_ie), .flash_busy(io.flash_busy));

    // ==========================================================
    // tasks
    task automatic finish_test;
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // one avalon access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        `CHK("waitrequest", 1'b0, avs_waitrequest)
        if (k >= 50)
            finish_test();
    endtask : av

    // poll status until a bit reaches a level
    task automatic wait_st(input int b, input logic v);
        int k;
        k = 0;
        do
        begin
            av(1'b0, eeprom_pkg::AV_STATUS, 32'h0);
            k++;
        end
        while (q[b] !== v && k < 400);
        `CHK("status bit", v, q[b])
    endtask : wait_st

    task automatic ee_write(input logic [8:0] a, input logic [7:0] d);
        wait_st(eeprom_pkg::ST_BUSY, 1'b0);
        av(1'b1, eeprom_pkg::AV_ADDR, {23'h0, a});
        av(1'b1, eeprom_pkg::AV_DATA, {24'h0, d});
        av(1'b1, eeprom_pkg::AV_CMD, 32'h1 << eeprom_pkg::CMD_WRITE);
    endtask : ee_write

    task automatic ee_read(input logic [8:0] a);
        wait_st(eeprom_pkg::ST_BUSY, 1'b0);
        av(1'b1, eeprom_pkg::AV_ADDR, {23'h0, a});
        av(1'b1, eeprom_pkg::AV_CMD, 32'h1 << eeprom_pkg::CMD_READ);
        wait_st(eeprom_pkg::ST_BUSY, 1'b0);
        av(1'b0, eeprom_pkg::AV_DATA, 32'h0);
    endtask : ee_read

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        por_n  <= 1'b1;
        foreach (rows[i])
            ee_write(rows[i][16:8], rows[i][7:0]);
        foreach (rows[i])
        begin
            ee_read(rows[i][16:8]);
            `CHK("byte", rows[i][7:0], q[7:0])
        end
        foreach (ie_rows[i])
        begin
            // ready ie reaches the controller with this read command's strobe control write, global ie through io.global_ie
            av(1'b1, eeprom_pkg::AV_CMD,
               {28'h0, ie_rows[i][3:0]} | (32'h1 << eeprom_pkg::CMD_READ));
            wait_st(eeprom_pkg::ST_BUSY, 1'b0);
            wait_st(eeprom_pkg::ST_IRQ, ie_rows[i][4]);
            av(1'b0, eeprom_pkg::AV_CMD, 32'h0);
            `CHK("cmd", ie_rows[i][3:0], q[3:0])
        end
        av(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, q)
        // flash programming holds a write back
        flash_prog_busy <= 1'b1;
        ee_write(9'h033, 8'h96);
        repeat (40) @(posedge clk_sys);
        av(1'b0, eeprom_pkg::AV_STATUS, 32'h0);
        `CHK("flash hold", 2'h3, {q[eeprom_pkg::ST_FLASH_BUSY], q[eeprom_pkg::ST_BUSY]})
        flash_prog_busy <= 1'b0;
        ee_read(9'h033);
        `CHK("after flash", 8'h96, q[7:0])
        // system reset in mid-write keeps the byte
        ee_write(9'h1A5, 8'h69);
        for (n = 0; n < 200 && io.stall !== 1'b1; n++)
            @(posedge clk_sys);
        `CHK("write stall", 1'b1, io.stall)
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        ee_read(9'h1A5);
        `CHK("across reset", 8'h69, q[7:0])
        finish_test();
    end
endmodule : eeprom_byte_access_ctrl_tb_top
